// ### logic/lgt_regs.svh
// Offsets, field positions, reset values and pin counts of the logic tile
`ifndef LGT_REGS_SVH
`define LGT_REGS_SVH

`define LGT_OFS_CTRL   8'h00
`define LGT_OFS_STAT   8'h04
`define LGT_SCFG_PAGE  4'h1
`define LGT_INIT_PAGE  3'h1

`define LGT_CTRL_USER  0
`define LGT_CTRL_RAM   1
`define LGT_CTRL_PSEUDO_DUAL_LUTRAM  2

`define LGT_CFG_SYNC   0
`define LGT_CFG_NEG    1
`define LGT_CFG_LATCH  2
`define LGT_CFG_RIPPLE 3
`define LGT_CFG_WIDE5  4
`define LGT_CFG_WIDEX  5
`define LGT_CFG_DSEL0  6
`define LGT_CFG_DSEL1  7
`define LGT_CFG_SRV0   8
`define LGT_CFG_SRV1   9

`define LGT_CTRL_RST   3'h0
`define LGT_SCFG_RST   10'h000
`define LGT_INIT_RST   16'h0000

`define LGT_NSLICE     4
`define LGT_PIN_W      52

`endif

// ### logic/lgt_pkg.sv
// Types shared by the logic tile files
package lgt_pkg;
  typedef logic [15:0] lgt_init_t;
  typedef logic [9:0]  lgt_cfg_t;
  typedef logic [2:0]  lgt_ctrl_t;
endpackage : lgt_pkg

// ### logic/lgt_slice.sv
// One slice: two LUT4s, carry pair, wide mux stage and two registers
`timescale 1ns/1ns
`include "lgt_regs.svh"
module lgt_slice
  import lgt_pkg::*;
(
  input  logic       clk,
  input  logic       rst_n,
  input  logic       user_mode,
  input  lgt_cfg_t   cfg,
  input  lgt_init_t  init0,
  input  lgt_init_t  init1,
  input  logic [3:0] lin0,
  input  logic [3:0] lin1,
  input  logic       m0,
  input  logic       m1,
  input  logic       ce,
  input  logic       local_set_reset,
  input  logic       sclk,
  input  logic       sclk_prv,
  input  logic       carry_in,
  input  logic       wide_in_a,
  input  logic       wide_in_b,
  output logic       f0,
  output logic       f1,
  output logic       w5,
  output logic       wx,
  output logic       carry_out,
  output logic       clk_edge,
  output logic       q0,
  output logic       q1
);

  logic lut0;
  logic lut1;
  logic c_mid;
  logic clk_lvl;
  logic act;
  logic sr_hit;
  logic d0;
  logic d1;

  assign lut0 = init0[lin0];
  assign lut1 = init1[lin1];

  assign w5 = m0 ? lut1 : lut0;

  assign wx = m1 ? wide_in_b : wide_in_a;

  assign c_mid     = lut0 ? carry_in : lin0[0];
  assign carry_out = lut1 ? c_mid : lin1[0];

  always_comb begin
    if (cfg[`LGT_CFG_RIPPLE]) begin
      f0 = lut0 ^ carry_in;
      f1 = lut1 ^ c_mid;
    end else begin
      f0 = cfg[`LGT_CFG_WIDE5] ? w5 : lut0;
      f1 = cfg[`LGT_CFG_WIDEX] ? wx : lut1;
    end
  end

  assign clk_lvl  = sclk ^ cfg[`LGT_CFG_NEG];
  assign clk_edge = clk_lvl & ~(sclk_prv ^ cfg[`LGT_CFG_NEG]);
  assign act      = cfg[`LGT_CFG_LATCH] ? clk_lvl : clk_edge;

  assign sr_hit = local_set_reset & (~cfg[`LGT_CFG_SYNC] | act);

  assign d0 = cfg[`LGT_CFG_DSEL0] ? m0 : f0;
  assign d1 = cfg[`LGT_CFG_DSEL1] ? m1 : f1;

  // Latch transparency is resolved at core clock rate only
  always_ff @(posedge clk) begin
    if (!rst_n || !user_mode) begin
      q0 <= cfg[`LGT_CFG_SRV0];
      q1 <= cfg[`LGT_CFG_SRV1];
    end else if (sr_hit) begin
      q0 <= cfg[`LGT_CFG_SRV0];
      q1 <= cfg[`LGT_CFG_SRV1];
    end else if (act && ce) begin
      q0 <= d0;
      q1 <= d1;
    end
  end

endmodule : lgt_slice

// ### logic/lgt_tile.sv
// Logic tile of four slices with APB configuration and LUT RAM support
// Operation
// - Tile holds slices 0 to 3, each two LUT4s feeding two registers.
// - In RAM use slices 0-2 serve memory; slice 3 stays logic only.
// - Register set/reset is configurable as synchronous or asynchronous.
// - Registers capture on either polarity, as flip-flop or latch.
// - Each slice takes 13 routing inputs plus one fast carry-in.
// - Each slice drives four routing outputs plus one fast carry-out.
// - Tile has 50 routing inputs and 16 routing outputs.
// - Combining logic builds five to eight input functions.
// - Two intermediate outputs and inputs per slice; LUT8 spans two tiles.
// - Slice 2 makes write clock from its clock, enable from set/reset.
// - Slice 2 gives data 3:2 to slice 1, 1:0 to slice 0, address.
// - After configuration every register holds its configured start value.
// - Both LUT results are output through core-clock flops beside the registered ones.
// - Carry enters from neighbour and leaves toward next tile.
// - Single port RAM: slices 0 and 1 form 16 by 4 memory.
// - Dual port RAM: one write updates both companion slices together.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
`include "lgt_regs.svh"
module lgt_tile
  import lgt_pkg::*;
(
  input  logic        CORE_CLK,
  input  logic        RSTN,
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [7:0]  PADDR,
  input  logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR,
  input  logic [31:0] LUT_IN,
  input  logic [3:0]  MULTI_PURPOSE_IN_0,
  input  logic [3:0]  MULTI_PURPOSE_IN_1,
  input  logic [3:0]  CLOCK_ENABLE,
  input  logic [3:0]  LOCAL_SET_RESET,
  input  logic [1:0]  SLICE_CLK,
  input  logic        CARRY_IN_FAST,
  input  logic        WIDE_FUNC_IN_B,
  output logic [7:0]  LUT_BYPASS_OUT,
  output logic [7:0]  REGISTERED_OUT,
  output logic [5:0]  WIDE_FUNC_OUT,
  output logic        CARRY_OUT_FAST
);

  localparam int NS = `LGT_NSLICE;

  // Pin synchronisers
  logic [`LGT_PIN_W-1:0] pin_s1_r;
  logic [`LGT_PIN_W-1:0] pin_s2_r;
  logic [1:0]            sclk_prv_r;

  // Configuration state
  lgt_ctrl_t             ctrl_r;
  lgt_cfg_t              scfg_r [NS];
  lgt_init_t             init_r [2*NS];

  // Bus answer
  logic [31:0]           prdata_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic [31:0]           rd_nxt;
  logic                  err_nxt;
  logic                  apb_setup;
  logic                  apb_wr;

  // Output flops
  logic [7:0]            fout_r;
  logic [5:0]            wout_r;
  logic                  cout_r;
  logic [7:0]            qcat;

  // Synchronised inputs
  logic [31:0]           lut_in_s;
  logic [3:0]            m0_s;
  logic [3:0]            m1_s;
  logic [3:0]            ce_s;
  logic [3:0]            lsr_s;
  logic [3:0]            lsr_g;
  logic [1:0]            sclk_s;
  logic                  cin_s;
  logic                  fxb_s;

  // Slice interconnect
  logic [NS:0]           carry;
  logic [NS-1:0]         f0;
  logic [NS-1:0]         f1;
  logic [NS-1:0]         w5;
  logic [NS-1:0]         wx;
  logic [NS-1:0]         wa;
  logic [NS-1:0]         wb;
  logic [NS-1:0]         edge_s;
  logic [NS-1:0]         q0;
  logic [NS-1:0]         q1;

  // Distributed RAM write port
  logic                  ram_we;
  logic [3:0]            ram_write_addr;
  logic [3:0]            ram_write_data;
  logic                  ram_en;
  logic                  pseudo_dual_lutram_en;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {WIDE_FUNC_IN_B, CARRY_IN_FAST, SLICE_CLK,
                   LOCAL_SET_RESET, CLOCK_ENABLE, MULTI_PURPOSE_IN_1,
                   MULTI_PURPOSE_IN_0, LUT_IN};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign {fxb_s, cin_s, sclk_s, lsr_s, ce_s, m1_s, m0_s, lut_in_s} =
    pin_s2_r;

  // Previous slice clock level for edge detection
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      sclk_prv_r <= 2'h0;
    end else begin
      sclk_prv_r <= sclk_s;
    end
  end

  // Control register
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ctrl_r <= `LGT_CTRL_RST;
    end else if (apb_wr && PADDR == `LGT_OFS_CTRL) begin
      ctrl_r <= lgt_ctrl_t'(PWDATA);
    end
  end

  assign ram_en  = ctrl_r[`LGT_CTRL_RAM];
  assign pseudo_dual_lutram_en = ctrl_r[`LGT_CTRL_PSEUDO_DUAL_LUTRAM];

  // Per-slice configuration registers
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      for (int i = 0; i < NS; i++) begin
        scfg_r[i] <= `LGT_SCFG_RST;
      end
    end else if (apb_wr && PADDR[7:4] == `LGT_SCFG_PAGE) begin
      scfg_r[PADDR[3:2]] <= lgt_cfg_t'(PWDATA);
    end
  end

  // Write clock is slice 2 clock, enable is its set/reset
  assign ram_we = ram_en & ctrl_r[`LGT_CTRL_USER] & lsr_s[2] & edge_s[2];
  // Address and data from slice 2 LUT inputs
  assign ram_write_addr = lut_in_s[19:16];
  assign ram_write_data = lut_in_s[23:20];

  // Slice 2 set/reset becomes write enable in RAM use
  assign lsr_g = lsr_s & ~{1'b0, ram_en, 2'b00};

  // LUT contents; a RAM write beats a bus write to the same bit
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      for (int i = 0; i < 2*NS; i++) begin
        init_r[i] <= `LGT_INIT_RST;
      end
    end else begin
      if (apb_wr && PADDR[7:5] == `LGT_INIT_PAGE) begin
        init_r[PADDR[4:2]] <= lgt_init_t'(PWDATA);
      end
      if (ram_we) begin
        init_r[0][ram_write_addr] <= ram_write_data[0];
        init_r[1][ram_write_addr] <= ram_write_data[1];
        // Companion slice written in same cycle
        init_r[2][ram_write_addr] <= pseudo_dual_lutram_en ? ram_write_data[0]
                                             : ram_write_data[2];
        init_r[3][ram_write_addr] <= pseudo_dual_lutram_en ? ram_write_data[1]
                                             : ram_write_data[3];
      end
    end
  end

  // Carry enters slice 0 from neighbour
  assign carry[0] = cin_s;

  // LUT6 in slices 0 and 2, LUT7 in 1, LUT8 in 3
  assign wa = {wx[1], w5[2], wx[0], w5[0]};
  assign wb = {fxb_s, w5[3], wx[2], w5[1]};

  for (genvar k = 0; k < NS; k++) begin : g_slice
    lgt_slice u_slice (
      .clk       (CORE_CLK),
      .rst_n     (RSTN),
      .user_mode (ctrl_r[`LGT_CTRL_USER]),
      .cfg       (scfg_r[k]),
      .init0     (init_r[2*k]),
      .init1     (init_r[2*k+1]),
      .lin0      (lut_in_s[8*k +: 4]),
      .lin1      (lut_in_s[8*k+4 +: 4]),
      .m0        (m0_s[k]),
      .m1        (m1_s[k]),
      .ce        (ce_s[k]),
      .local_set_reset       (lsr_g[k]),
      .sclk      (sclk_s[k/2]),
      .sclk_prv  (sclk_prv_r[k/2]),
      .carry_in  (carry[k]),
      .wide_in_a (wa[k]),
      .wide_in_b (wb[k]),
      .f0        (f0[k]),
      .f1        (f1[k]),
      .w5        (w5[k]),
      .wx        (wx[k]),
      .carry_out (carry[k+1]),
      .clk_edge  (edge_s[k]),
      .q0        (q0[k]),
      .q1        (q1[k])
    );
    assign qcat[2*k +: 2] = {q1[k], q0[k]};
  end

  // Bypass, wide and carry outputs registered
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      fout_r <= 8'h00;
      wout_r <= 6'h00;
      cout_r <= 1'b0;
    end else begin
      for (int k = 0; k < NS; k++) begin
        fout_r[2*k]   <= f0[k];
        fout_r[2*k+1] <= f1[k];
      end
      wout_r <= {wx, w5[3], w5[1]};
      cout_r <= carry[NS];
    end
  end

  assign LUT_BYPASS_OUT = fout_r;
  assign REGISTERED_OUT = qcat;
  assign WIDE_FUNC_OUT  = wout_r;
  assign CARRY_OUT_FAST = cout_r;

  // Read mux and address check, evaluated in the setup cycle
  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (PADDR == `LGT_OFS_CTRL) begin
      rd_nxt = 32'(ctrl_r);
    end else if (PADDR == `LGT_OFS_STAT) begin
      rd_nxt = {9'h000, wout_r, cout_r, fout_r, qcat};
    end else if (PADDR[1:0] != 2'h0) begin
      err_nxt = 1'b1;
    end else if (PADDR[7:4] == `LGT_SCFG_PAGE) begin
      rd_nxt = 32'(scfg_r[PADDR[3:2]]);
    end else if (PADDR[7:5] == `LGT_INIT_PAGE) begin
      rd_nxt = 32'(init_r[PADDR[4:2]]);
    end else begin
      err_nxt = 1'b1;
    end
  end

  assign apb_setup = PSEL & ~PENABLE;
  // Error transfers never write
  assign apb_wr = PSEL & PENABLE & PWRITE & pready_r & ~pslverr_r;

  // Single wait-free access phase after every setup
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup & err_nxt;
      if (apb_setup) begin
        prdata_r <= rd_nxt;
      end
    end
  end

  assign PRDATA  = prdata_r;
  assign PREADY  = pready_r;
  assign PSLVERR = pslverr_r;

endmodule : lgt_tile

// ### tb/lgt_monitor.sv
// Port-level checks of the logic tile
`timescale 1ns/1ns
module lgt_monitor (
  input logic        CORE_CLK,
  input logic        RSTN,
  input logic        PSEL,
  input logic        PENABLE,
  input logic [31:0] PRDATA,
  input logic        PREADY,
  input logic        PSLVERR,
  input logic [7:0]  LUT_BYPASS_OUT,
  input logic [7:0]  REGISTERED_OUT,
  input logic [5:0]  WIDE_FUNC_OUT,
  input logic        CARRY_OUT_FAST
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_access; PSEL && PENABLE && PREADY; endsequence
  // No wait states, so the access answers at once
  property p_access; s_setup |=> s_access; endproperty
  property p_pulse; s_access |=> !PREADY; endproperty
  property p_origin; $rose(PREADY) |-> $past(PSEL && !PENABLE); endproperty
  property p_inacc; PREADY |-> PSEL && PENABLE; endproperty
  property p_idle; !PSEL |=> !PREADY; endproperty
  property p_err; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
  property p_hold; (PREADY ##1 !PSEL) |-> $stable(PRDATA); endproperty
  // Must hold while reset is low, so no disable
  property p_rst;
    disable iff (1'b0) !RSTN ##1 !RSTN |=> !PREADY && !PSLVERR
      && !CARRY_OUT_FAST
      && REGISTERED_OUT == 8'h00 && LUT_BYPASS_OUT == 8'h00
      && WIDE_FUNC_OUT == 6'h00;
  endproperty
  a_access: assert property (p_access) else $error("access not answered");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_origin: assert property (p_origin) else $error("ready without setup");
  a_inacc: assert property (p_inacc) else $error("ready outside access");
  a_idle: assert property (p_idle) else $error("ready while idle");
  a_err: assert property (p_err) else $error("bad error answer");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule : lgt_monitor

bind lgt_tile lgt_monitor mon (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .LUT_BYPASS_OUT(LUT_BYPASS_OUT),
  .REGISTERED_OUT(REGISTERED_OUT), .WIDE_FUNC_OUT(WIDE_FUNC_OUT),
  .CARRY_OUT_FAST(CARRY_OUT_FAST));

// ### tb/lgt_fabric.sv
// Routing fabric model making slice clock pulses
`timescale 1ns/1ns
module lgt_fabric (
  input  logic       clk,
  input  logic [1:0] go,
  output logic [1:0] sclk
);
  logic [2:0] cnt_r [2] = '{3'h0, 3'h0};
  // High phase of three core cycles so the tile can sample it
  always_ff @(posedge clk) begin
    for (int b = 0; b < 2; b++) begin
      if (go[b]) cnt_r[b] <= 3'h6;
      else if (cnt_r[b] != 3'h0) cnt_r[b] <= cnt_r[b] - 3'h1;
    end
  end
  assign sclk = {cnt_r[1] > 3'h3, cnt_r[0] > 3'h3};
endmodule : lgt_fabric

// ### tb/tb_top.sv
// Self-checking bench of the logic tile
`timescale 1ns/1ns
`include "lgt_regs.svh"
module tb_top;
  logic        clk, rstn, psel, pen, pwr, prdy, perr, rerr, co;
  logic [7:0]  padr, fo, qo, qx;
  logic [31:0] pwd, prd, rdat, lin;
  logic [3:0]  ce, local_set_reset, a, d;
  logic [1:0]  sclk, go;
  logic [5:0]  wo;
  logic [15:0] tbl [8];
  logic [3:0]  m0, m1;
  logic        ci;
  logic [6:0]  wcx;
  logic [31:0] rv;
  int          err_count, tests_run, cyc;

  always #20 clk = ~clk;
  lgt_tile uut (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .LUT_IN(lin), .MULTI_PURPOSE_IN_0(m0),
    .MULTI_PURPOSE_IN_1(m1), .CLOCK_ENABLE(ce), .LOCAL_SET_RESET(local_set_reset),
    .SLICE_CLK(sclk), .CARRY_IN_FAST(ci), .WIDE_FUNC_IN_B(1'b0),
    .LUT_BYPASS_OUT(fo), .REGISTERED_OUT(qo), .WIDE_FUNC_OUT(wo),
    .CARRY_OUT_FAST(co));
  lgt_fabric fab (.clk(clk), .go(go), .sclk(sclk));

  function automatic logic [7:0] fexp(input logic [31:0] l);
    for (int b = 0; b < 8; b++) fexp[b] = tbl[b][l[4*b+:4]];
  endfunction : fexp
  // Wide stage and carry chain, neighbour LUT7 input held low
  function automatic logic [6:0] wcexp(input logic [31:0] l,
                                       input logic [3:0] mv0, mv1,
                                       input logic cv);
    logic [3:0] l0, l1, w5, wx;
    logic       c;
    c = cv;
    for (int k = 0; k < 4; k++) begin
      l0[k] = tbl[2*k][l[8*k+:4]];
      l1[k] = tbl[2*k+1][l[8*k+4+:4]];
      w5[k] = mv0[k] ? l1[k] : l0[k];
      c = l0[k] ? c : l[8*k];
      c = l1[k] ? c : l[8*k+4];
    end
    wx[0] = mv1[0] ? w5[1] : w5[0];
    wx[2] = mv1[2] ? w5[3] : w5[2];
    wx[1] = mv1[1] ? wx[2] : wx[0];
    wx[3] = mv1[3] ? 1'b0 : wx[1];
    return {wx, w5[3], w5[1], c};
  endfunction : wcexp
  // Companion slices copy the low pair in dual port use
  function automatic logic ramx(input logic [3:0] v, input int i, p);
    return (p != 0 && i > 1) ? v[i-2] : v[i];
  endfunction : ramx
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] v);
    psel <= 1; pwr <= w; padr <= ad; pwd <= v;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rdat = prd; rerr = perr;
    psel <= 0; pen <= 0;
    @(posedge clk);
  endtask : apb
  task pulse(input logic [1:0] b);
    go <= b;
    @(posedge clk) go <= 2'h0;
    repeat (10) @(posedge clk);
  endtask : pulse
  task wrap_up;
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    clk = 0; rstn = 0; psel = 0; pen = 0; pwr = 0; padr = 0; pwd = 0;
    lin = 0; ce = 0; local_set_reset = 0; go = 0; m0 = 0; m1 = 0; ci = 0;
    void'($urandom(41));
    repeat (3) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    apb(0, `LGT_OFS_CTRL, 0); chk(rdat, 0);
    for (int i = 0; i < 12; i++) begin
      apb(0, 8'(8'h10 + 4*i), 0); chk(rdat, 0);
    end
    chk(qo, 0);
    apb(0, 8'h40, 0);
    chk(rerr, 1);
    chk(rdat, 0);
    apb(1, 8'h02, 32'hffffffff); chk(rerr, 1);
    for (int k = 0; k < 4; k++) begin
      rv = $urandom;
      apb(1, 8'(8'h10 + 4*k), rv);
      apb(0, 8'(8'h10 + 4*k), 0); chk(rdat, {22'h0, rv[9:0]});
      apb(1, 8'(8'h10 + 4*k), 0);
    end
    for (int i = 0; i < 8; i++) begin
      tbl[i] = $urandom;
      apb(1, 8'(8'h20 + 4*i), {16'h0, tbl[i]});
    end
    apb(1, `LGT_OFS_CTRL, 32'h1);
    for (int r = 0; r < 6; r++) begin
      lin <= (r == 0) ? 32'h0 : (r == 1) ? 32'hffffffff : $urandom;
      m0 <= 4'($urandom);
      m1 <= 4'($urandom);
      ci <= 1'($urandom);
      repeat (6) @(posedge clk);
      chk(fo, fexp(lin));
      wcx = wcexp(lin, m0, m1, ci);
      chk(wo, wcx[6:1]);
      chk(co, wcx[0]);
    end
    ce <= 4'hf;
    qx = fexp(lin);
    pulse(2'h3); chk(qo, qx);
    ce <= 4'h0; lin <= ~lin;
    pulse(2'h3); chk(qo, qx);
    local_set_reset <= 4'hf;
    repeat (6) @(posedge clk);
    chk(qo, 0);
    ce <= 4'hf;
    local_set_reset <= 4'h0;
    pulse(2'h3);
    qx = fexp(lin);
    chk(qo, qx);
    // Synchronous set/reset must wait for the slice clock
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'(8'h10 + 4*k), 32'h1);
    end
    local_set_reset <= 4'hf;
    repeat (6) @(posedge clk);
    chk(qo, qx);
    pulse(2'h3);
    chk(qo, 0);
    local_set_reset <= 4'h0;
    for (int p = 0; p < 2; p++) begin
      apb(1, `LGT_OFS_CTRL, p ? 32'h7 : 32'h3);
      a = $urandom; d = $urandom;
      lin <= {8'h0, d, a, 16'h0}; local_set_reset <= 4'h4;
      pulse(2'h2);
      local_set_reset <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        apb(0, 8'(8'h20 + 4*i), 0); chk(rdat[a], ramx(d, i, p));
      end
    end
    wrap_up();
  end
endmodule : tb_top
